/* File: logic/rsq_pkg.sv */
package rsq_pkg;
   // ************************************************************
   // timing figures, in sync clock periods unless noted
   // ************************************************************
   localparam int RSQ_IN_ASSERT_MIN = 32;
   localparam int RSQ_OUT_ASSERT_MIN = 512;
   localparam int RSQ_HARD_TO_SOFT_MIN = 16;
   localparam int RSQ_STRAP_SETUP_MIN = 4;
   localparam int RSQ_STRAP_REDRIVE_MIN = 1;
   localparam int RSQ_STRAP_OFF_NS = 4;
   localparam int RSQ_CLK_PERIOD_NS = 40;
   localparam int RSQ_PLL_LOCK_US = 100;
   localparam int RSQ_PLL_LOCK_CYC = RSQ_PLL_LOCK_US * 1000 / RSQ_CLK_PERIOD_NS;
   localparam int RSQ_CNT_W = 12;
   localparam int RSQ_SRC_W = 3;
   localparam logic [RSQ_SRC_W-1:0] RSQ_SRC_RST = 3'h0;
   localparam logic [RSQ_CNT_W-1:0] RSQ_CNT_ZERO = 12'h000;
   localparam logic [RSQ_CNT_W-1:0] RSQ_CNT_ONE = 12'h001;

   // ************************************************************
   // sequencer states
   // ************************************************************
   typedef enum logic [4:0]
   {
      RSQ_POR = 5'b00001,
      RSQ_LOCK = 5'b00010,
      RSQ_HARD = 5'b00100,
      RSQ_SOFT = 5'b01000,
      RSQ_RUN = 5'b10000
   } rsq_state_type;
endpackage

/* File: logic/rsq_ref_div.sv */
`timescale 1ns/1ps
// ************************************************************
// reference clock enable divider
// ************************************************************
module rsq_ref_div
   import rsq_pkg::*;
(
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic div_sel_i,
   output logic tick_o
);
   typedef struct packed
   {
      logic phase;
      logic tick;
   } rsq_div_type;

   rsq_div_type st;
   rsq_div_type next_st;

   // divide by two when div_sel_i is set (divider strap and host mode), else every cycle
   always_comb
   begin
      next_st = st;
      if (div_sel_i)
      begin
         next_st.phase = ~st.phase;
         next_st.tick = st.phase;
      end
      else
      begin
         next_st.phase = 1'b0;
         next_st.tick = 1'b1;
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         st <= '0;
      else
         st <= next_st;
   end

   assign tick_o = st.tick;
endmodule

/* File: logic/rsq_sequencer.sv */
`timescale 1ns/1ps
// Functional notes
// - drive both resets 512 periods; soft negates 16 periods after hard.
// - strap pins released within 4 ns of hard reset assertion.
// - strap pins redriven at least 1 sync period after hard negation.
// - configuration is three reset source bits, one divider bit and the host mode bit.
// - host mode: sync period follows the sampled divider strap.
// - agent mode: all reset timing counts sync clock periods.
// - wait for pll lock, within 100 us, before releasing resets.
// - primary clock from primary input in host, sync input in agent.
module rsq_sequencer
   import rsq_pkg::*;
#(
   parameter int PLL_LOCK_CYC = RSQ_PLL_LOCK_CYC
)
(
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic host_mode_i,
   input wire logic power_on_reset_in_n_i,
   input wire logic hard_reset_line_i,
   input wire logic soft_reset_line_i,
   input wire logic pll_lock_i,
   input wire logic [RSQ_SRC_W-1:0] reset_source_strap_i,
   input wire logic clock_divider_strap_i,
   output logic hard_reset_line_o,
   output logic hard_reset_line_oe_o,
   output logic soft_reset_line_o,
   output logic soft_reset_line_oe_o,
   output logic strap_oe_o,
   output logic [RSQ_SRC_W-1:0] reset_source_o,
   output logic clock_divider_o,
   output logic ref_is_sync_o,
   output logic pll_fail_o
);
   // ************************************************************
   // state
   // ************************************************************
   typedef struct packed
   {
      rsq_state_type fsm;
      logic [1:0] por_s;
      logic [1:0] hard_s;
      logic [1:0] soft_s;
      logic [1:0] lock_s;
      logic [RSQ_SRC_W+1:0] cfg_s0;
      logic [RSQ_SRC_W+1:0] cfg_s1;
      logic [RSQ_CNT_W-1:0] cnt;
      logic [RSQ_CNT_W-1:0] in_cnt;
      logic [31:0] lock_cnt;
      logic [RSQ_SRC_W-1:0] src;
      logic div;
      logic host;
      logic hard_drv;
      logic soft_drv;
      logic strap_oe;
      logic fail;
      logic [9:0] hold;
      logic [4:0] gap;
   } rsq_seq_type;

   rsq_seq_type st;
   rsq_seq_type next_st;
   logic tick;
   logic por_low;
   logic ext_low;

   // sync period follows the divider strap in host mode only; in agent
   // mode the clock already is the sync clock, so every cycle counts
   rsq_ref_div u_div
   (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .div_sel_i(st.div & st.host),
      .tick_o(tick)
   );

   // inputs are read only after the second synchroniser stage
   assign por_low = ~st.por_s[1];
   assign ext_low = ~st.hard_s[1] | ~st.soft_s[1];

   // ************************************************************
   // next state
   // ************************************************************
   always_comb
   begin
      next_st = st;
      next_st.por_s = {st.por_s[0], power_on_reset_in_n_i};
      next_st.hard_s = {st.hard_s[0], hard_reset_line_i};
      next_st.soft_s = {st.soft_s[0], soft_reset_line_i};
      next_st.lock_s = {st.lock_s[0], pll_lock_i};
      // strap and mode pins are asynchronous as well: two stages first
      next_st.cfg_s0 = {host_mode_i, clock_divider_strap_i, reset_source_strap_i};
      next_st.cfg_s1 = st.cfg_s0;
      // check helpers: ticks of hard hold, and ticks from hard to soft release
      if (!st.hard_drv)
         next_st.hold = '0;
      else if (tick && st.hold != '1)
         next_st.hold = st.hold + 10'h001;
      if (st.hard_drv)
         next_st.gap = '0;
      else if (tick && st.soft_drv && st.gap != '1)
         next_st.gap = st.gap + 5'h01;
      if (por_low)
      begin
         // straps are tracked while power-on reset is low, so the last
         // sample before negation is what stays; pins never go stale
         next_st.fsm = RSQ_POR;
         next_st.src = st.cfg_s1[RSQ_SRC_W-1:0];
         next_st.div = st.cfg_s1[RSQ_SRC_W];
         next_st.host = st.cfg_s1[RSQ_SRC_W+1];
         next_st.hard_drv = 1'b1;
         next_st.soft_drv = 1'b1;
         next_st.strap_oe = 1'b0;
         next_st.cnt = RSQ_CNT_ZERO;
         next_st.lock_cnt = '0;
      end
      else
      begin
         // external reset must stand 32 sync periods before it counts
         if (ext_low && st.fsm == RSQ_RUN)
         begin
            if (tick)
               next_st.in_cnt = st.in_cnt + RSQ_CNT_ONE;
            if (st.in_cnt >= RSQ_CNT_W'(RSQ_IN_ASSERT_MIN - 1) && tick)
            begin
               next_st.fsm = RSQ_HARD;
               next_st.hard_drv = 1'b1;
               next_st.soft_drv = 1'b1;
               next_st.strap_oe = 1'b0;
               next_st.cnt = RSQ_CNT_ZERO;
               next_st.in_cnt = RSQ_CNT_ZERO;
            end
         end
         else
            next_st.in_cnt = RSQ_CNT_ZERO;
         unique case (st.fsm)
            RSQ_POR:
            begin
               next_st.fsm = RSQ_LOCK;
            end
            RSQ_LOCK:
            begin
               // downstream resets stay held until the pll reports lock
               if (st.lock_s[1])
                  next_st.fsm = RSQ_HARD;
               else if (st.lock_cnt >= 32'(PLL_LOCK_CYC))
                  next_st.fail = 1'b1;
               else
                  next_st.lock_cnt = st.lock_cnt + 32'd1;
            end
            RSQ_HARD:
            begin
               if (tick)
                  next_st.cnt = st.cnt + RSQ_CNT_ONE;
               if (tick && st.cnt >= RSQ_CNT_W'(RSQ_OUT_ASSERT_MIN - 1))
               begin
                  next_st.fsm = RSQ_SOFT;
                  next_st.hard_drv = 1'b0;
                  next_st.cnt = RSQ_CNT_ZERO;
               end
            end
            RSQ_SOFT:
            begin
               if (tick)
                  next_st.cnt = st.cnt + RSQ_CNT_ONE;
               // straps come back one sync period after hard negation
               if (tick && st.cnt == RSQ_CNT_W'(RSQ_STRAP_REDRIVE_MIN - 1))
                  next_st.strap_oe = 1'b1;
               if (tick && st.cnt >= RSQ_CNT_W'(RSQ_HARD_TO_SOFT_MIN - 1))
               begin
                  next_st.fsm = RSQ_RUN;
                  next_st.soft_drv = 1'b0;
                  next_st.cnt = RSQ_CNT_ZERO;
               end
            end
            RSQ_RUN:
            begin
               next_st.cnt = RSQ_CNT_ZERO;
            end
            default:
            begin
               next_st.fsm = RSQ_POR;
            end
         endcase
      end
   end

   // ************************************************************
   // registers
   // ************************************************************
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         st <= '0;
         st.fsm <= RSQ_POR;
         st.hard_drv <= 1'b1;
         st.soft_drv <= 1'b1;
         st.src <= RSQ_SRC_RST;
      end
      else
         st <= next_st;
   end

   // reset lines are open drain: drive low only, enable while asserting
   assign hard_reset_line_o = 1'b0;
   assign soft_reset_line_o = 1'b0;
   assign hard_reset_line_oe_o = st.hard_drv;
   assign soft_reset_line_oe_o = st.soft_drv;
   assign strap_oe_o = st.strap_oe;
   assign reset_source_o = st.src;
   assign clock_divider_o = st.div;
   assign ref_is_sync_o = ~st.host;
   assign pll_fail_o = st.fail;

   // ************************************************************
   // checks
   // ************************************************************
   hard_hold_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      $fell(st.hard_drv) |-> $past(st.hold) >= 10'(RSQ_OUT_ASSERT_MIN - 1))
      else $error("hard reset released too early");

   // the lag counter is independent of the sequencer count, so a short
   // soft phase in any divider setting shows up here
   soft_after_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      $fell(st.soft_drv) |-> st.gap >= 5'(RSQ_HARD_TO_SOFT_MIN))
      else $error("soft reset released too soon after hard");

   strap_off_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (st.fsm == RSQ_HARD) |-> !st.strap_oe)
      else $error("straps driven during hard reset");

   strap_on_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      $fell(st.hard_drv) |-> !st.strap_oe)
      else $error("straps redriven with hard negation");

   strap_hold_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (st.fsm != RSQ_POR && $past(st.fsm) != RSQ_POR) |-> $stable(st.src) && $stable(st.div))
      else $error("captured straps changed");

   lock_wait_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (st.fsm == RSQ_LOCK && !st.lock_s[1]) |=> st.fsm != RSQ_HARD)
      else $error("left lock wait without lock");

   ext_min_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      ($past(st.fsm) == RSQ_RUN && st.fsm == RSQ_HARD)
         |-> $past(st.in_cnt) >= RSQ_CNT_W'(RSQ_IN_ASSERT_MIN - 1))
      else $error("external reset taken too short");

   // tick leaves reset low, so the check looks one edge after the select
   div_ref_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      !(st.div && st.host) |=> tick)
      else $error("reference tick missing");

   div_half_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (st.div && st.host && tick) |=> !tick)
      else $error("divided tick not halved");
endmodule

/* File: testbench/reset_init_sequencer_tb.sv */
`timescale 1ns/1ps
module reset_init_sequencer_tb;
   import rsq_pkg::*;
   logic clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic host_mode = 1'b1;
   logic pll_lock = 1'b0;
   logic por_n, hard_line, soft_line, div_strap, div_pin;
   logic hard_o, hard_oe, soft_o, soft_oe, strap_oe, clk_div, ref_sync, pll_fail;
   logic [RSQ_SRC_W-1:0] src_strap, src_pin, src_out;
   int mismatches = 0;
   int total_checks = 0;

   always #20 clk_i = ~clk_i;
   // strap pins carry the device value while it drives them
   assign src_pin = strap_oe ? src_out : src_strap;
   assign div_pin = strap_oe ? clk_div : div_strap;

   rsq_board board (.clk_i(clk_i), .hard_oe_i(hard_oe), .soft_oe_i(soft_oe),
      .power_on_reset_in_n_o(por_n), .hard_reset_line_o(hard_line),
      .soft_reset_line_o(soft_line), .strap_o(src_strap), .clock_divider_strap_o(div_strap));
   rsq_sequencer #(.PLL_LOCK_CYC(20)) dut (.clk_i(clk_i), .resetn_i(resetn_i),
      .host_mode_i(host_mode), .power_on_reset_in_n_i(por_n), .hard_reset_line_i(hard_line),
      .soft_reset_line_i(soft_line), .pll_lock_i(pll_lock), .reset_source_strap_i(src_pin),
      .clock_divider_strap_i(div_pin), .hard_reset_line_o(hard_o),
      .hard_reset_line_oe_o(hard_oe), .soft_reset_line_o(soft_o),
      .soft_reset_line_oe_o(soft_oe), .strap_oe_o(strap_oe), .reset_source_o(src_out),
      .clock_divider_o(clk_div), .ref_is_sync_o(ref_sync), .pll_fail_o(pll_fail));

   task automatic check(input string name, input logic [11:0] exp, input logic [11:0] got);
      total_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("BAD %s expected %0d seen %0d", name, exp, got);
      end
   endtask

   // times one drive of the reset lines and checks the negation order
   task automatic watch(input int tl, output int hlen);
      int n, sgap, pgap, clash;
      n = 0;
      hlen = 0;
      sgap = 0;
      pgap = -1;
      clash = 0;
      while (hard_oe !== 1'b1 && n < 3000)
      begin
         @(negedge clk_i);
         n++;
      end
      while (hard_oe === 1'b1 && hlen < 5000)
      begin
         if (strap_oe !== 1'b0) clash++;
         @(negedge clk_i);
         hlen++;
      end
      while (soft_oe === 1'b1 && sgap < 5000)
      begin
         if (strap_oe === 1'b1 && pgap < 0) pgap = sgap;
         @(negedge clk_i);
         sgap++;
      end
      if (pgap < 0 && strap_oe === 1'b1) pgap = sgap;
      check("strap_off", 0, clash);
      check("soft_gap", 1, sgap >= 16 * tl && sgap <= 16 * tl + 2);
      check("strap_on", 1, pgap >= tl);
      check("hard_o", 0, hard_o);
      check("soft_o", 0, soft_o);
   endtask

   task automatic t_host_power_up;
      int hlen;
      // host mode with the divider strap set: one sync period is two clocks
      host_mode = 1'b1;
      board.power_up(3'h5, 1'b1, 2);
      repeat (4) @(negedge clk_i);
      check("hold_for_lock", 1, hard_oe);
      pll_lock = 1'b1;
      watch(2, hlen);
      check("src", 3'h5, src_out);
      check("div", 1, clk_div);
      check("ref_sync", 0, ref_sync);
      check("pll_fail", 0, pll_fail);
   endtask

   task automatic t_ext_reset;
      int hlen, seen;
      seen = 0;
      fork
         board.pulse_hard(20);
         repeat (600) @(negedge clk_i) seen |= int'(hard_oe);
      join
      check("short_ignored", 0, seen);
      fork
         board.pulse_hard(80);
         watch(2, hlen);
      join
      check("hard_len", 1, hlen >= 512 * 2 && hlen <= 512 * 2 + 8);
      check("src_kept", 3'h5, src_out);
   endtask

   task automatic t_agent_slow_lock;
      int hlen;
      resetn_i = 1'b0;
      pll_lock = 1'b0;
      host_mode = 1'b0;
      @(negedge clk_i);
      resetn_i = 1'b1;
      // agent mode captures the divider strap but does not divide by it: the clock is the sync clock
      board.power_up(3'h3, 1'b1, 1);
      repeat (60) @(negedge clk_i);
      check("pll_fail", 1, pll_fail);
      pll_lock = 1'b1;
      watch(1, hlen);
      check("ref_sync", 1, ref_sync);
      check("src", 3'h3, src_out);
      check("div", 1, clk_div);
   endtask

   task automatic complete_run;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // watchdog well beyond the few thousand cycles the scenarios need
   initial
   begin
      repeat (20000) @(posedge clk_i);
      mismatches++;
      complete_run();
   end

   initial
   begin
      repeat (8) @(negedge clk_i);
      resetn_i = 1'b1;
      t_host_power_up();
      t_ext_reset();
      t_agent_slow_lock();
      complete_run();
   end
endmodule

/* File: testbench/rsq_board.sv */
`timescale 1ns/1ps
// ************************************************************
// board reset supervisor and strap pull network
// ************************************************************
module rsq_board
   import rsq_pkg::*;
(
   input wire logic clk_i,
   input wire logic hard_oe_i,
   input wire logic soft_oe_i,
   output logic power_on_reset_in_n_o,
   output logic hard_reset_line_o,
   output logic soft_reset_line_o,
   output logic [RSQ_SRC_W-1:0] strap_o,
   output logic clock_divider_strap_o
);
   logic ext_hard = 1'b0;

   // wired lines with pull-up: any party pulling makes them low
   assign hard_reset_line_o = ~(hard_oe_i | ext_hard);
   assign soft_reset_line_o = ~soft_oe_i;

   initial
   begin
      power_on_reset_in_n_o = 1'b0;
      strap_o = 3'h0;
      clock_divider_strap_o = 1'b0;
   end

   // straps settle first, power-on held well past the minimum, straps scrambled after
   task automatic power_up(input logic [RSQ_SRC_W-1:0] src, input logic div, input int tl);
      power_on_reset_in_n_o = 1'b0;
      strap_o = src;
      clock_divider_strap_o = div;
      repeat (40 * tl) @(negedge clk_i);
      power_on_reset_in_n_o = 1'b1;
      repeat (6 * tl) @(negedge clk_i);
      strap_o = ~src;
      clock_divider_strap_o = ~div;
   endtask

   // outside agent pulls the hard line for n cycles
   task automatic pulse_hard(input int n);
      ext_hard = 1'b1;
      repeat (n) @(negedge clk_i);
      ext_hard = 1'b0;
   endtask
endmodule
